// File: rtl/iptc_pkg.sv
/*
  Package of the interrupt priority and trap control block: register
  offsets, field positions, reset values and bus carriers.
  Assumes a 16-bit register port with word offsets on an 8-bit address.
*/
`default_nettype none
package iptc_pkg;

  // ----------------------------------------------------------------
  // Bus and data widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CPU_STATUS = 8'h00;
  localparam logic [7:0] OFS_CORE_CTRL = 8'h01;
  localparam logic [7:0] OFS_TCS1 = 8'h02;
  localparam logic [7:0] OFS_TCS2 = 8'h03;
  localparam logic [7:0] OFS_TCS3 = 8'h04;
  localparam logic [7:0] OFS_TCS4 = 8'h05;
  localparam logic [7:0] OFS_PENDING = 8'h06;
  localparam logic [7:0] OFS_EVT_STATUS = 8'h07;
  localparam logic [7:0] OFS_EVT_MASK = 8'h08;
  localparam logic [7:0] OFS_FLAG_BASE = 8'h10;
  localparam logic [7:0] OFS_ENABLE_BASE = 8'h20;
  localparam logic [7:0] OFS_PRIO_BASE = 8'h40;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ST_LEVEL_LSB = 5;
  localparam int CC_VAR_BIT = 15;
  localparam int CC_LEVEL_HI_BIT = 3;
  localparam int T1_NO_NEST_BIT = 15;
  localparam int T1_OVA_BIT = 14;
  localparam int T1_OVB_BIT = 13;
  localparam int T1_COVA_BIT = 12;
  localparam int T1_COVB_BIT = 11;
  localparam int T1_OVA_EN_BIT = 10;
  localparam int T1_OVB_EN_BIT = 9;
  localparam int T1_COV_EN_BIT = 8;
  localparam int T1_SHIFT_BIT = 7;
  localparam int T1_DIV0_BIT = 6;
  localparam int T1_DMA_BIT = 5;
  localparam int T1_MATH_BIT = 4;
  localparam int T2_GLOBAL_EN_BIT = 15;
  localparam int T3_DMA_ADDR_BIT = 5;
  localparam int T3_LOOP_OVF_BIT = 4;
  localparam int T4_SW_HARD_BIT = 0;
  localparam int PV_LEVEL_LSB = 8;
  localparam int PRIO_FIELD_W = 4;
  localparam int PRIO_PER_REG = 4;
  localparam int BITS_PER_REG = 16;
  localparam int EVT_W = 6;

  // ----------------------------------------------------------------
  // Reset values and constants
  // ----------------------------------------------------------------
  localparam logic RST_GLOBAL_EN = 1'b1;
  localparam logic RST_NO_NEST = 1'b0;
  localparam logic [2:0] RST_EDGE_POL = 3'h0;
  localparam logic [2:0] RST_PRIO = 3'h0;
  localparam logic [7:0] FIRST_USER_VECTOR = 8'h08;
  localparam logic [2:0] LEVEL_ALL_BLOCKED = 3'h7;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } iptc_bus_t;

  typedef struct packed {
    logic [3:0] level;
    logic [7:0] vector;
  } iptc_pend_t;

endpackage : iptc_pkg

`default_nettype wire

// File: rtl/iptc_top.sv
/*
  Interrupt priority and trap control: request flags, enables and
  priorities, arbitration, pending vector latch, CPU level and trap flags.
  Assumes one clock, synchronous inputs, one-cycle event pulses from
  peripherals and the core, and a core that loads its level on entry/return.
*/
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Each source has a request flag set by hardware, cleared by software.
// - Each source has its own enable bit.
// - Each source has a 3-bit priority choosing one of eight levels.
// - Pending vector number and its level are latched, read-only.
// - Flag, enable, priority positions follow vector order from vector 8.
// - CPU level low bits sit at status bits 7:5 and are writable.
// - CPU level top bit in core control cannot be written by software.
// - CPU level is top bit above low bits; top bit set blocks users.
// - Low bits 111 block every user interrupt.
// - Nesting disable makes the low level bits read-only to software.
// - Control 1 bit 15 disables nesting, resets to zero.
// - Core control bit 15 selects variable or fixed exception latency.
// - Accumulator overflow and catastrophic overflow trap flags at 14..11.
// - Bits 10, 9, 8 arm A, B and catastrophic overflow traps.
// - Math trap sets bit 4 plus bit 7 shift or bit 6 divide cause.
// - Control 1 bit 5 reads one after a DMA controller trap.
// - Control 3 holds DMA and loop-stack traps; control 4 software trap.
// - Global enable gates all user interrupts, resets to one.
module iptc_top #(
  parameter int NUM_SRC = 16
) (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  // Register port
  input wire iptc_pkg::iptc_bus_t BUS_REQ,
  output logic [15:0] BUS_RDATA,
  // Peripheral requests
  input wire logic [NUM_SRC-1:0] SRC_REQ,
  // Trap causes from the core
  input wire logic ACC_A_OVF,
  input wire logic ACC_B_OVF,
  input wire logic ACC_A_CAT,
  input wire logic ACC_B_CAT,
  input wire logic BAD_SHIFT,
  input wire logic DIVIDE_ZERO,
  input wire logic DMA_TRAP,
  input wire logic DMA_ADDR_ERR,
  input wire logic LOOP_STACK_OVF,
  input wire logic SW_HARD_TRAP,
  // Core level load
  input wire logic CPU_LEVEL_LOAD,
  input wire logic [3:0] CPU_LEVEL_IN,
  // Core side outputs
  output logic IRQ_VALID,
  output iptc_pkg::iptc_pend_t IRQ_PEND,
  output logic [3:0] CPU_LEVEL,
  output logic NEST_DISABLE,
  output logic LATENCY_VAR,
  // Interrupt output
  output logic IRQ
);

  localparam int NFREG = (NUM_SRC + iptc_pkg::BITS_PER_REG - 1)
                         / iptc_pkg::BITS_PER_REG;
  localparam int NPREG = (NUM_SRC + iptc_pkg::PRIO_PER_REG - 1)
                         / iptc_pkg::PRIO_PER_REG;

  logic [NUM_SRC-1:0] flag_reg;
  logic [NUM_SRC-1:0] enable_reg;
  logic [2:0] prio_reg [NUM_SRC];
  logic [2:0] level_lo_reg;
  logic level_hi_reg;
  logic var_reg;
  logic no_nest_reg;
  logic ova_reg, ovb_reg, cova_reg, covb_reg;
  logic ova_en_reg, ovb_en_reg, cov_en_reg;
  logic shift_reg, div0_reg, dma_reg, math_reg;
  logic global_en_reg;
  logic [2:0] edge_pol_reg;
  logic dma_addr_reg, loop_ovf_reg, sw_hard_reg;
  logic pend_valid_reg;
  iptc_pkg::iptc_pend_t pend_reg;
  logic [iptc_pkg::EVT_W-1:0] evt_reg;
  logic [iptc_pkg::EVT_W-1:0] evt_mask_reg;
  logic [15:0] rdata_reg;

  logic wr, rd;
  logic [7:0] addr;
  logic [15:0] wd;
  logic [3:0] cpu_level;
  logic win_valid;
  logic [7:0] win_vector;
  logic [2:0] win_prio;
  logic math_evt, acc_evt;
  logic [iptc_pkg::EVT_W-1:0] evt_set;

  assign wr = BUS_REQ.wr;
  assign rd = BUS_REQ.rd;
  assign addr = BUS_REQ.addr;
  assign wd = BUS_REQ.wdata;

  // ----------------------------------------------------------------
  // Per-source flag, enable and priority
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NUM_SRC; i++)
  begin : g_src
    localparam logic [7:0] FREG = 8'(i / iptc_pkg::BITS_PER_REG);
    localparam int FBIT = i % iptc_pkg::BITS_PER_REG;
    localparam logic [7:0] PREG = 8'(i / iptc_pkg::PRIO_PER_REG);
    localparam int PLSB = (i % iptc_pkg::PRIO_PER_REG)
                          * iptc_pkg::PRIO_FIELD_W;

    always_ff @(posedge CORE_CLK or negedge ARST_N)
    begin
      if (!ARST_N)
        flag_reg[i] <= 1'b0;
      else if (SRC_REQ[i])
        flag_reg[i] <= 1'b1;
      else if (wr && addr == iptc_pkg::OFS_FLAG_BASE + FREG)
        flag_reg[i] <= wd[FBIT];
    end

    always_ff @(posedge CORE_CLK or negedge ARST_N)
    begin
      if (!ARST_N)
        enable_reg[i] <= 1'b0;
      else if (wr && addr == iptc_pkg::OFS_ENABLE_BASE + FREG)
        enable_reg[i] <= wd[FBIT];
    end

    always_ff @(posedge CORE_CLK or negedge ARST_N)
    begin
      if (!ARST_N)
        prio_reg[i] <= iptc_pkg::RST_PRIO;
      else if (wr && addr == iptc_pkg::OFS_PRIO_BASE + PREG)
        prio_reg[i] <= wd[PLSB +: 3];
    end
  end

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  assign cpu_level = {level_hi_reg, level_lo_reg};

  always_comb
  begin
    win_valid = 1'b0;
    win_vector = 8'h00;
    win_prio = 3'h0;
    // Highest index first so that an equal lower index takes over
    for (int i = NUM_SRC - 1; i >= 0; i--)
    begin
      if (flag_reg[i] && enable_reg[i] && global_en_reg
          && {1'b0, prio_reg[i]} > cpu_level
          && (!win_valid || prio_reg[i] >= win_prio))
      begin
        win_valid = 1'b1;
        win_prio = prio_reg[i];
        win_vector = iptc_pkg::FIRST_USER_VECTOR + 8'(i);
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      pend_valid_reg <= 1'b0;
      pend_reg <= '0;
    end
    else
    begin
      pend_valid_reg <= win_valid;
      if (win_valid)
      begin
        pend_reg.vector <= win_vector;
        pend_reg.level <= {1'b0, win_prio};
      end
    end
  end

  // ----------------------------------------------------------------
  // CPU level and core control
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      level_lo_reg <= 3'h0;
      level_hi_reg <= 1'b0;
    end
    else if (CPU_LEVEL_LOAD)
    begin
      level_lo_reg <= CPU_LEVEL_IN[2:0];
      level_hi_reg <= CPU_LEVEL_IN[3];
    end
    else if (wr && addr == iptc_pkg::OFS_CPU_STATUS && !no_nest_reg)
      level_lo_reg <= wd[iptc_pkg::ST_LEVEL_LSB +: 3];
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      var_reg <= 1'b0;
    else if (wr && addr == iptc_pkg::OFS_CORE_CTRL)
      var_reg <= wd[iptc_pkg::CC_VAR_BIT];
  end

  // ----------------------------------------------------------------
  // Trap control and status
  // ----------------------------------------------------------------
  assign math_evt = BAD_SHIFT | DIVIDE_ZERO;
  assign acc_evt = (ACC_A_OVF & ova_en_reg) | (ACC_B_OVF & ovb_en_reg)
                   | ((ACC_A_CAT | ACC_B_CAT) & cov_en_reg);

  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      no_nest_reg <= iptc_pkg::RST_NO_NEST;
      ova_en_reg <= 1'b0;
      ovb_en_reg <= 1'b0;
      cov_en_reg <= 1'b0;
    end
    else if (wr && addr == iptc_pkg::OFS_TCS1)
    begin
      no_nest_reg <= wd[iptc_pkg::T1_NO_NEST_BIT];
      ova_en_reg <= wd[iptc_pkg::T1_OVA_EN_BIT];
      ovb_en_reg <= wd[iptc_pkg::T1_OVB_EN_BIT];
      cov_en_reg <= wd[iptc_pkg::T1_COV_EN_BIT];
    end
  end

  // Sticky trap flags: a hardware set wins over a software write
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      {ova_reg, ovb_reg, cova_reg, covb_reg} <= 4'h0;
      {shift_reg, div0_reg, dma_reg, math_reg} <= 4'h0;
    end
    else
    begin
      if (wr && addr == iptc_pkg::OFS_TCS1)
      begin
        ova_reg <= wd[iptc_pkg::T1_OVA_BIT] | (ACC_A_OVF & ova_en_reg);
        ovb_reg <= wd[iptc_pkg::T1_OVB_BIT] | (ACC_B_OVF & ovb_en_reg);
        cova_reg <= wd[iptc_pkg::T1_COVA_BIT] | (ACC_A_CAT & cov_en_reg);
        covb_reg <= wd[iptc_pkg::T1_COVB_BIT] | (ACC_B_CAT & cov_en_reg);
        shift_reg <= wd[iptc_pkg::T1_SHIFT_BIT] | BAD_SHIFT;
        div0_reg <= wd[iptc_pkg::T1_DIV0_BIT] | DIVIDE_ZERO;
        dma_reg <= wd[iptc_pkg::T1_DMA_BIT] | DMA_TRAP;
        math_reg <= wd[iptc_pkg::T1_MATH_BIT] | math_evt;
      end
      else
      begin
        ova_reg <= ova_reg | (ACC_A_OVF & ova_en_reg);
        ovb_reg <= ovb_reg | (ACC_B_OVF & ovb_en_reg);
        cova_reg <= cova_reg | (ACC_A_CAT & cov_en_reg);
        covb_reg <= covb_reg | (ACC_B_CAT & cov_en_reg);
        shift_reg <= shift_reg | BAD_SHIFT;
        div0_reg <= div0_reg | DIVIDE_ZERO;
        dma_reg <= dma_reg | DMA_TRAP;
        math_reg <= math_reg | math_evt;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      global_en_reg <= iptc_pkg::RST_GLOBAL_EN;
      edge_pol_reg <= iptc_pkg::RST_EDGE_POL;
    end
    else if (wr && addr == iptc_pkg::OFS_TCS2)
    begin
      global_en_reg <= wd[iptc_pkg::T2_GLOBAL_EN_BIT];
      edge_pol_reg <= wd[2:0];
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      dma_addr_reg <= 1'b0;
      loop_ovf_reg <= 1'b0;
      sw_hard_reg <= 1'b0;
    end
    else
    begin
      if (wr && addr == iptc_pkg::OFS_TCS3)
      begin
        dma_addr_reg <= wd[iptc_pkg::T3_DMA_ADDR_BIT] | DMA_ADDR_ERR;
        loop_ovf_reg <= wd[iptc_pkg::T3_LOOP_OVF_BIT] | LOOP_STACK_OVF;
      end
      else
      begin
        dma_addr_reg <= dma_addr_reg | DMA_ADDR_ERR;
        loop_ovf_reg <= loop_ovf_reg | LOOP_STACK_OVF;
      end
      if (wr && addr == iptc_pkg::OFS_TCS4)
        sw_hard_reg <= wd[iptc_pkg::T4_SW_HARD_BIT] | SW_HARD_TRAP;
      else
        sw_hard_reg <= sw_hard_reg | SW_HARD_TRAP;
    end
  end

  // ----------------------------------------------------------------
  // Event status, mask and interrupt line
  // ----------------------------------------------------------------
  assign evt_set = {win_valid & ~pend_valid_reg, SW_HARD_TRAP,
                    LOOP_STACK_OVF | DMA_ADDR_ERR, DMA_TRAP, acc_evt,
                    math_evt};

  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      evt_reg <= '0;
    else if (wr && addr == iptc_pkg::OFS_EVT_STATUS)
      evt_reg <= (evt_reg & ~wd[iptc_pkg::EVT_W-1:0]) | evt_set;
    else
      evt_reg <= evt_reg | evt_set;
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      evt_mask_reg <= '0;
    else if (wr && addr == iptc_pkg::OFS_EVT_MASK)
      evt_mask_reg <= wd[iptc_pkg::EVT_W-1:0];
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      rdata_reg <= 16'h0000;
    else if (rd)
    begin
      rdata_reg <= 16'h0000;
      case (addr)
        iptc_pkg::OFS_CPU_STATUS:
          rdata_reg[iptc_pkg::ST_LEVEL_LSB +: 3] <= level_lo_reg;
        iptc_pkg::OFS_CORE_CTRL:
        begin
          rdata_reg[iptc_pkg::CC_VAR_BIT] <= var_reg;
          rdata_reg[iptc_pkg::CC_LEVEL_HI_BIT] <= level_hi_reg;
        end
        iptc_pkg::OFS_TCS1:
          rdata_reg[15:4] <= {no_nest_reg, ova_reg, ovb_reg, cova_reg,
                              covb_reg, ova_en_reg, ovb_en_reg, cov_en_reg,
                              shift_reg, div0_reg, dma_reg, math_reg};
        iptc_pkg::OFS_TCS2:
        begin
          rdata_reg[iptc_pkg::T2_GLOBAL_EN_BIT] <= global_en_reg;
          rdata_reg[2:0] <= edge_pol_reg;
        end
        iptc_pkg::OFS_TCS3:
        begin
          rdata_reg[iptc_pkg::T3_DMA_ADDR_BIT] <= dma_addr_reg;
          rdata_reg[iptc_pkg::T3_LOOP_OVF_BIT] <= loop_ovf_reg;
        end
        iptc_pkg::OFS_TCS4:
          rdata_reg[iptc_pkg::T4_SW_HARD_BIT] <= sw_hard_reg;
        iptc_pkg::OFS_PENDING:
          rdata_reg[11:0] <= pend_reg;
        iptc_pkg::OFS_EVT_STATUS:
          rdata_reg[iptc_pkg::EVT_W-1:0] <= evt_reg;
        iptc_pkg::OFS_EVT_MASK:
          rdata_reg[iptc_pkg::EVT_W-1:0] <= evt_mask_reg;
        default:
        begin
          for (int r = 0; r < NFREG; r++)
            for (int b = 0; b < iptc_pkg::BITS_PER_REG; b++)
              if (r * iptc_pkg::BITS_PER_REG + b < NUM_SRC)
              begin
                if (addr == iptc_pkg::OFS_FLAG_BASE + 8'(r))
                  rdata_reg[b] <= flag_reg[r * iptc_pkg::BITS_PER_REG + b];
                if (addr == iptc_pkg::OFS_ENABLE_BASE + 8'(r))
                  rdata_reg[b] <= enable_reg[r * iptc_pkg::BITS_PER_REG + b];
              end
          for (int r = 0; r < NPREG; r++)
            for (int k = 0; k < iptc_pkg::PRIO_PER_REG; k++)
              if (r * iptc_pkg::PRIO_PER_REG + k < NUM_SRC
                  && addr == iptc_pkg::OFS_PRIO_BASE + 8'(r))
                rdata_reg[k * iptc_pkg::PRIO_FIELD_W +: 3]
                  <= prio_reg[r * iptc_pkg::PRIO_PER_REG + k];
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign BUS_RDATA = rdata_reg;
  assign IRQ_VALID = pend_valid_reg;
  assign IRQ_PEND = pend_reg;
  assign CPU_LEVEL = cpu_level;
  assign NEST_DISABLE = no_nest_reg;
  assign LATENCY_VAR = var_reg;
  assign IRQ = |(evt_reg & evt_mask_reg);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);

  AST_FLAG_STICKY: assert property (SRC_REQ[0] |=> flag_reg[0] ##0
    (flag_reg[0] [*2] or (wr && addr == iptc_pkg::OFS_FLAG_BASE)))
    else $error("request flag not held");
  AST_NO_ENABLE: assert property ((flag_reg & enable_reg) == '0
    |=> !IRQ_VALID) else $error("pending without enabled flag");
  AST_PRIO_WRITE: assert property (
    wr && addr == iptc_pkg::OFS_PRIO_BASE
    |=> prio_reg[0] == $past(wd[2:0])) else $error("priority not stored");
  AST_PEND_ABOVE: assert property (win_valid |=> IRQ_VALID
    && IRQ_PEND.level > $past(cpu_level) && IRQ_PEND.level[3] == 1'b0)
    else $error("pending level wrong");
  AST_VEC_RANGE: assert property (IRQ_VALID |->
    IRQ_PEND.vector >= iptc_pkg::FIRST_USER_VECTOR
    && IRQ_PEND.vector < iptc_pkg::FIRST_USER_VECTOR + 8'(NUM_SRC))
    else $error("vector out of range");
  AST_LEVEL_WRITE: assert property (
    wr && addr == iptc_pkg::OFS_CPU_STATUS && !no_nest_reg && !CPU_LEVEL_LOAD
    |=> level_lo_reg == $past(wd[7:5]))
    else $error("level bits not written");
  AST_MSB_RO: assert property (
    !CPU_LEVEL_LOAD |=> $stable(level_hi_reg))
    else $error("top level bit changed by software");
  AST_TOP_BLOCKS: assert property (level_hi_reg |=> !IRQ_VALID)
    else $error("user interrupt above level seven");
  AST_SEVEN_BLOCKS: assert property (
    level_lo_reg == iptc_pkg::LEVEL_ALL_BLOCKED
    |=> !IRQ_VALID) else $error("user interrupt at level seven");
  AST_NEST_RO: assert property (no_nest_reg && !CPU_LEVEL_LOAD
    |=> $stable(level_lo_reg)) else $error("level written while nesting off");
  AST_MATH: assert property (BAD_SHIFT |=> math_reg && shift_reg)
    else $error("math trap flags not set");
  AST_DMA: assert property (DMA_TRAP |=> dma_reg [*2] or
    (dma_reg ##1 ($past(wr) && $past(addr) == iptc_pkg::OFS_TCS1)))
    else $error("dma trap flag not set");
  AST_GLOBAL_EN: assert property (!global_en_reg |=> !IRQ_VALID)
    else $error("interrupt with global enable off");

  COV_PENDING: cover property (!IRQ_VALID ##1 IRQ_VALID);
  COV_NEST_OFF: cover property (no_nest_reg && wr
    && addr == iptc_pkg::OFS_CPU_STATUS);
  COV_ACC_TRAP: cover property (acc_evt ##1 IRQ);
  COV_TIE: cover property (win_valid && flag_reg[0] && flag_reg[1]);

endmodule : iptc_top

`default_nettype wire

// File: test/iptc_core_model.sv
/*
  Core side model: takes a pending request by loading its level,
  or loads a level that the bench asks for (trap entry or return).
  Assumes the block's registered IRQ_VALID and IRQ_PEND outputs.
*/
`timescale 1ns/1ps
`default_nettype none
module iptc_core_model (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Block outputs
  input wire logic irq_valid,
  input wire iptc_pkg::iptc_pend_t pend,
  // Bench control
  input wire logic accept,
  input wire logic load_req,
  input wire logic [3:0] load_val,
  // Level load to the block
  output logic level_load,
  output logic [3:0] level_in
);
  logic seen_reg;

  // ----------------------------------------------------------------
  // Level load, once per newly valid accepted pending request, or on a bench request
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      level_load <= 1'b0;
      level_in <= 4'h0;
      seen_reg <= 1'b0;
    end
    else
    begin
      seen_reg <= irq_valid;
      level_load <= (accept && irq_valid && !seen_reg) || load_req;
      if (accept && irq_valid && !seen_reg)
        level_in <= pend.level;
      else if (load_req)
        level_in <= load_val;
    end
  end
endmodule : iptc_core_model
`default_nettype wire

// File: test/iptc_top_tb_top.sv
/*
  Self-checking bench: register, arbitration, level and trap checks.
  Assumes the core model beside the block and word offsets of the package.
*/
`timescale 1ns/1ps
`default_nettype none
module iptc_top_tb_top;
  logic clk, arst_n, accept, load_req, lv_load, irq_valid, irq, nd, lat;
  logic [3:0] load_val, lv_in, cpu_lvl;
  logic [15:0] rdata, src;
  logic [9:0] tr;
  iptc_pkg::iptc_bus_t req;
  iptc_pkg::iptc_pend_t pend;
  int mismatches, comparisons;
  logic [15:0] exp1 [7] = '{16'h4700, 16'h2700, 16'h1700, 16'h0F00,
                            16'h0790, 16'h0750, 16'h0720};

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  iptc_top #(.NUM_SRC(16)) dut_u (.CORE_CLK(clk), .ARST_N(arst_n),
    .BUS_REQ(req), .BUS_RDATA(rdata), .SRC_REQ(src), .ACC_A_OVF(tr[0]),
    .ACC_B_OVF(tr[1]), .ACC_A_CAT(tr[2]), .ACC_B_CAT(tr[3]),
    .BAD_SHIFT(tr[4]), .DIVIDE_ZERO(tr[5]), .DMA_TRAP(tr[6]),
    .DMA_ADDR_ERR(tr[7]), .LOOP_STACK_OVF(tr[8]), .SW_HARD_TRAP(tr[9]),
    .CPU_LEVEL_LOAD(lv_load), .CPU_LEVEL_IN(lv_in), .IRQ_VALID(irq_valid),
    .IRQ_PEND(pend), .CPU_LEVEL(cpu_lvl), .NEST_DISABLE(nd),
    .LATENCY_VAR(lat), .IRQ(irq));

  iptc_core_model core_u (.clk(clk), .arst_n(arst_n),
    .irq_valid(irq_valid), .pend(pend), .accept(accept),
    .load_req(load_req), .load_val(load_val), .level_load(lv_load),
    .level_in(lv_in));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    #1 chk(rdata, e);
  endtask : rd

  task trap(input int i);
    @(posedge clk);
    tr[i] <= 1'b1;
    @(posedge clk);
    tr <= '0;
  endtask : trap

  task wait_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_n

  task finish_test;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test

  // ----------------------------------------------------------------
  // Run limit
  // ----------------------------------------------------------------
  initial
  begin
    repeat (5000) @(posedge clk);
    mismatches++;
    finish_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {arst_n, accept, load_req, load_val, src, tr} = '0;
    req = '0;
    mismatches = 0;
    comparisons = 0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    rd(8'h03, 16'h8000);
    rd(8'h02, 16'h0000);
    rd(8'h06, 16'h0000);
    rd(8'hFF, 16'h0000);
    wr(8'h00, 16'h00A0);
    rd(8'h00, 16'h00A0);
    chk({12'h0, cpu_lvl}, 16'h0005);
    wr(8'h01, 16'h8008);
    rd(8'h01, 16'h8000);
    chk({15'h0, lat}, 16'h0001);
    wr(8'h02, 16'h8000);
    wr(8'h00, 16'h0000);
    rd(8'h00, 16'h00A0);
    chk({15'h0, nd}, 16'h0001);
    wr(8'h02, 16'h0000);
    wr(8'h00, 16'h0000);
    // Two sources, priorities 2 and 5
    wr(8'h40, 16'h0052);
    wr(8'h20, 16'h0003);
    @(posedge clk);
    src <= 16'h0003;
    @(posedge clk);
    src <= '0;
    wait_n(1);
    chk({3'h0, irq_valid, pend}, 16'h1509);
    rd(8'h06, 16'h0509);
    rd(8'h10, 16'h0003);
    wr(8'h00, 16'h00A0);
    wait_n(2);
    chk({15'h0, irq_valid}, 16'h0000);
    wr(8'h00, 16'h0020);
    wait_n(2);
    chk({3'h0, irq_valid, pend}, 16'h1509);
    wr(8'h10, 16'h0001);
    wait_n(2);
    chk({3'h0, irq_valid, pend}, 16'h1208);
    wr(8'h00, 16'h00E0);
    wait_n(2);
    chk({15'h0, irq_valid}, 16'h0000);
    wr(8'h00, 16'h0000);
    wr(8'h20, 16'h0002);
    wait_n(2);
    chk({15'h0, irq_valid}, 16'h0000);
    wr(8'h20, 16'h0003);
    wr(8'h03, 16'h0000);
    wait_n(2);
    chk({15'h0, irq_valid}, 16'h0000);
    wr(8'h03, 16'h8000);
    wait_n(2);
    chk({15'h0, irq_valid}, 16'h0001);
    // Core enters a trap, level 8
    @(posedge clk);
    load_req <= 1'b1;
    load_val <= 4'h8;
    @(posedge clk);
    load_req <= 1'b0;
    wait_n(2);
    chk({12'h0, cpu_lvl}, 16'h0008);
    chk({15'h0, irq_valid}, 16'h0000);
    wr(8'h01, 16'h8000);
    rd(8'h01, 16'h8008);
    // Return to level 0, core takes the pending source
    @(posedge clk);
    load_req <= 1'b1;
    load_val <= 4'h0;
    accept <= 1'b1;
    @(posedge clk);
    load_req <= 1'b0;
    wait_n(10);
    chk({12'h0, cpu_lvl}, 16'h0002);
    accept <= 1'b0;
    // Event status, mask and interrupt line
    wr(8'h07, 16'h003F);
    wr(8'h08, 16'h0000);
    trap(4);
    wait_n(1);
    chk({15'h0, irq}, 16'h0000);
    rd(8'h07, 16'h0001);
    wr(8'h08, 16'h0001);
    #1 chk({15'h0, irq}, 16'h0001);
    wr(8'h07, 16'h0001);
    #1 chk({15'h0, irq}, 16'h0000);
    // Trap flags
    wr(8'h02, 16'h0000);
    trap(0);
    rd(8'h02, 16'h0000);
    for (int i = 0; i < 7; i++)
    begin
      wr(8'h02, 16'h0700);
      trap(i);
      rd(8'h02, exp1[i]);
    end
    trap(7);
    trap(8);
    rd(8'h04, 16'h0030);
    trap(9);
    rd(8'h05, 16'h0001);
    finish_test();
  end
endmodule : iptc_top_tb_top
`default_nettype wire
